// File: logic/pmc_pkg.sv
// constants for the port pin mode configuration block
package pmc_pkg;

  // ----------------------------------------------------------------
  // special-function register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FIRST_LOW   = 8'hB1;
  localparam logic [7:0] ADDR_FIRST_HIGH  = 8'hB2;
  localparam logic [7:0] ADDR_SECOND_LOW  = 8'hB3;
  localparam logic [7:0] ADDR_SECOND_HIGH = 8'hB4;

  // ----------------------------------------------------------------
  // reset values and unmapped read value
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_REG_RESET   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PORT_WIDTH     = 8;
  localparam int FIELD_WIDTH    = 2;
  localparam int PINS_PER_REG   = 4;
  localparam int NUM_PINS       = 16;
  localparam int READ_STROBE_PIN  = 15;
  localparam int WRITE_STROBE_PIN = 14;

  // ----------------------------------------------------------------
  // pin mode encodings, high bit then low bit
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PULLUP     = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL  = 2'h1;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] MODE_INPUT      = 2'h3;

endpackage : pmc_pkg

// File: logic/pmc_pin_if.sv
// per-pin control and pad signals between the mode logic and a pin driver
`timescale 1ns/10ps

interface pmc_pin_if;
  logic [1:0] mode;
  logic       latch;
  logic       ovr_en;
  logic       ovr_out;
  logic       ovr_oe;
  logic       pad_in;
  logic       pad_out;
  logic       pad_oe;
  logic       pull_en;
  logic       pin_level;

  modport ctrl
  (
    output mode,
    output latch,
    output ovr_en,
    output ovr_out,
    output ovr_oe,
    output pad_in,
    input  pad_out,
    input  pad_oe,
    input  pull_en,
    input  pin_level
  );

  modport drv
  (
    input  mode,
    input  latch,
    input  ovr_en,
    input  ovr_out,
    input  ovr_oe,
    input  pad_in,
    output pad_out,
    output pad_oe,
    output pull_en,
    output pin_level
  );
endinterface : pmc_pin_if

// File: logic/pmc_pin_drv.sv
// one pin's output driver, pull-up control and input sampling
`timescale 1ns/10ps

module pmc_pin_drv
(
  input  wire logic clock,
  input  wire logic srst,
  pmc_pin_if.drv    bus
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic pad_out_reg;
  logic pad_out_next;
  logic pad_oe_reg;
  logic pad_oe_next;
  logic pull_en_reg;
  logic pull_en_next;
  logic level_reg;
  logic level_next;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    pad_out_next = 1'b0;
    pad_oe_next  = 1'b0;
    pull_en_next = 1'b0;
    level_next   = bus.pad_in;
    if (bus.ovr_en)
    begin
      // memory interface owns the pin, mode field ignored
      pad_out_next = bus.ovr_out;
      pad_oe_next  = bus.ovr_oe;
    end
    else
    begin
      case (bus.mode)
        pmc_pkg::MODE_PULLUP:
        begin
          // quasi-bidirectional: strong low, weak high
          pad_out_next = 1'b0;
          pad_oe_next  = ~bus.latch;
          pull_en_next = 1'b1;
        end
        pmc_pkg::MODE_PUSH_PULL:
        begin
          pad_out_next = bus.latch;
          pad_oe_next  = 1'b1;
        end
        pmc_pkg::MODE_OPEN_DRAIN:
        begin
          pad_out_next = 1'b0;
          pad_oe_next  = ~bus.latch;
        end
        pmc_pkg::MODE_INPUT:
        begin
          pad_oe_next  = 1'b0;
        end
        default:
        begin
          pad_oe_next  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pad_out_reg <= 1'b0;
      pad_oe_reg  <= 1'b0;
      pull_en_reg <= 1'b0;
      level_reg   <= 1'b0;
    end
    else
    begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg  <= pad_oe_next;
      pull_en_reg <= pull_en_next;
      level_reg   <= level_next;
    end
  end

  assign bus.pad_out   = pad_out_reg;
  assign bus.pad_oe    = pad_oe_reg;
  assign bus.pull_en   = pull_en_reg;
  assign bus.pin_level = level_reg;

endmodule : pmc_pin_drv

// File: logic/pmc_port_mode.sv
// pin mode configuration registers and pad control for two 8-bit ports
`timescale 1ns/10ps

module pmc_port_mode
#(
  parameter int PORT_W = pmc_pkg::PORT_WIDTH
)
(
  input  wire logic              clock,
  input  wire logic              srst,
  // special-function register bus
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_rd,
  output logic      [7:0]        sfr_rdata,
  output logic                   sfr_rd_hit,
  // external memory control
  input  wire logic              external_access_pin_n,
  input  wire logic              external_memory_select_bit,
  input  wire logic [PORT_W-1:0] mem_bus_out,
  input  wire logic              mem_bus_oe,
  input  wire logic              mem_read_strobe_n,
  input  wire logic              mem_write_strobe_n,
  output logic                   mem_route_active,
  // first port
  input  wire logic [PORT_W-1:0] first_latch,
  input  wire logic [PORT_W-1:0] first_pad_in,
  output logic      [PORT_W-1:0] first_pad_out,
  output logic      [PORT_W-1:0] first_pad_oe,
  output logic      [PORT_W-1:0] first_pull_en,
  output logic      [PORT_W-1:0] first_pin_level,
  // second port
  input  wire logic [PORT_W-1:0] second_latch,
  input  wire logic [PORT_W-1:0] second_pad_in,
  output logic      [PORT_W-1:0] second_pad_out,
  output logic      [PORT_W-1:0] second_pad_oe,
  output logic      [PORT_W-1:0] second_pull_en,
  output logic      [PORT_W-1:0] second_pin_level
);

  localparam int NPINS = 2 * PORT_W;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] first_port_mode_low_reg;
  logic [7:0] first_port_mode_low_next;
  logic [7:0] first_port_mode_high_reg;
  logic [7:0] first_port_mode_high_next;
  logic [7:0] second_port_mode_low_reg;
  logic [7:0] second_port_mode_low_next;
  logic [7:0] second_port_mode_high_reg;
  logic [7:0] second_port_mode_high_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rd_hit_reg;
  logic       rd_hit_next;

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_comb
  begin
    first_port_mode_low_next   = first_port_mode_low_reg;
    first_port_mode_high_next  = first_port_mode_high_reg;
    second_port_mode_low_next  = second_port_mode_low_reg;
    second_port_mode_high_next = second_port_mode_high_reg;
    if (sfr_wr)
    begin
      case (sfr_addr)
        pmc_pkg::ADDR_FIRST_LOW:   first_port_mode_low_next   = sfr_wdata;
        pmc_pkg::ADDR_FIRST_HIGH:  first_port_mode_high_next  = sfr_wdata;
        pmc_pkg::ADDR_SECOND_LOW:  second_port_mode_low_next  = sfr_wdata;
        pmc_pkg::ADDR_SECOND_HIGH: second_port_mode_high_next = sfr_wdata;
        default:
        begin
          first_port_mode_low_next = first_port_mode_low_reg;
        end
      endcase
    end
    rdata_next  = pmc_pkg::READ_UNMAPPED;
    rd_hit_next = 1'b0;
    if (sfr_rd)
    begin
      rd_hit_next = 1'b1;
      case (sfr_addr)
        pmc_pkg::ADDR_FIRST_LOW:   rdata_next = first_port_mode_low_reg;
        pmc_pkg::ADDR_FIRST_HIGH:  rdata_next = first_port_mode_high_reg;
        pmc_pkg::ADDR_SECOND_LOW:  rdata_next = second_port_mode_low_reg;
        pmc_pkg::ADDR_SECOND_HIGH: rdata_next = second_port_mode_high_reg;
        default:
        begin
          // address belongs to another block
          rdata_next  = pmc_pkg::READ_UNMAPPED;
          rd_hit_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      first_port_mode_low_reg   <= pmc_pkg::MODE_REG_RESET;
      first_port_mode_high_reg  <= pmc_pkg::MODE_REG_RESET;
      second_port_mode_low_reg  <= pmc_pkg::MODE_REG_RESET;
      second_port_mode_high_reg <= pmc_pkg::MODE_REG_RESET;
      rdata_reg                 <= pmc_pkg::READ_UNMAPPED;
      rd_hit_reg                <= 1'b0;
    end
    else
    begin
      first_port_mode_low_reg   <= first_port_mode_low_next;
      first_port_mode_high_reg  <= first_port_mode_high_next;
      second_port_mode_low_reg  <= second_port_mode_low_next;
      second_port_mode_high_reg <= second_port_mode_high_next;
      rdata_reg                 <= rdata_next;
      rd_hit_reg                <= rd_hit_next;
    end
  end

  assign sfr_rdata  = rdata_reg;
  assign sfr_rd_hit = rd_hit_reg;

  // ----------------------------------------------------------------
  // external memory routing
  // ----------------------------------------------------------------
  logic             mem_sel;
  logic [NPINS-1:0] ovr_en;
  logic [NPINS-1:0] ovr_out;
  logic [NPINS-1:0] ovr_oe;

  // external access pin low or the select bit set puts memory on the pins
  assign mem_sel          = ~external_access_pin_n | external_memory_select_bit;
  assign mem_route_active = mem_sel;

  always_comb
  begin
    ovr_en  = '0;
    ovr_out = '0;
    ovr_oe  = '0;
    ovr_en[PORT_W-1:0]  = {PORT_W{mem_sel}};
    ovr_out[PORT_W-1:0] = mem_bus_out;
    ovr_oe[PORT_W-1:0]  = {PORT_W{mem_bus_oe}};
    // strobes driven regardless of latch and mode field
    ovr_en[pmc_pkg::READ_STROBE_PIN]   = mem_sel;
    ovr_out[pmc_pkg::READ_STROBE_PIN]  = mem_read_strobe_n;
    ovr_oe[pmc_pkg::READ_STROBE_PIN]   = 1'b1;
    ovr_en[pmc_pkg::WRITE_STROBE_PIN]  = mem_sel;
    ovr_out[pmc_pkg::WRITE_STROBE_PIN] = mem_write_strobe_n;
    ovr_oe[pmc_pkg::WRITE_STROBE_PIN]  = 1'b1;
  end

  // ----------------------------------------------------------------
  // per-pin drivers
  // ----------------------------------------------------------------
  logic [4*8-1:0]   mode_vec;
  logic [NPINS-1:0] latch_vec;
  logic [NPINS-1:0] pad_in_vec;
  logic [NPINS-1:0] pad_out_vec;
  logic [NPINS-1:0] pad_oe_vec;
  logic [NPINS-1:0] pull_vec;
  logic [NPINS-1:0] level_vec;

  assign mode_vec   = {second_port_mode_high_reg, second_port_mode_low_reg,
                       first_port_mode_high_reg, first_port_mode_low_reg};
  assign latch_vec  = {second_latch, first_latch};
  assign pad_in_vec = {second_pad_in, first_pad_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      pmc_pin_if pin_bus ();

      // pin n of a group of four takes bits 2n+1:2n of its register
      assign pin_bus.mode    = mode_vec[gi*pmc_pkg::FIELD_WIDTH +: pmc_pkg::FIELD_WIDTH];
      assign pin_bus.latch   = latch_vec[gi];
      assign pin_bus.ovr_en  = ovr_en[gi];
      assign pin_bus.ovr_out = ovr_out[gi];
      assign pin_bus.ovr_oe  = ovr_oe[gi];
      assign pin_bus.pad_in  = pad_in_vec[gi];

      pmc_pin_drv u_drv
      (
        .clock (clock),
        .srst  (srst),
        .bus   (pin_bus.drv)
      );

      assign pad_out_vec[gi] = pin_bus.pad_out;
      assign pad_oe_vec[gi]  = pin_bus.pad_oe;
      assign pull_vec[gi]    = pin_bus.pull_en;
      assign level_vec[gi]   = pin_bus.pin_level;
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad outputs
  // ----------------------------------------------------------------
  assign first_pad_out    = pad_out_vec[PORT_W-1:0];
  assign first_pad_oe     = pad_oe_vec[PORT_W-1:0];
  assign first_pull_en    = pull_vec[PORT_W-1:0];
  assign first_pin_level  = level_vec[PORT_W-1:0];
  assign second_pad_out   = pad_out_vec[NPINS-1:PORT_W];
  assign second_pad_oe    = pad_oe_vec[NPINS-1:PORT_W];
  assign second_pull_en   = pull_vec[NPINS-1:PORT_W];
  assign second_pin_level = level_vec[NPINS-1:PORT_W];

endmodule : pmc_port_mode

// File: test/pmc_port_mode_chk.sv
// assertions on the ports of the pin mode block
`timescale 1ns/10ps

module pmc_port_mode_chk
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_rd_hit,
  input wire logic       external_access_pin_n,
  input wire logic       external_memory_select_bit,
  input wire logic [7:0] mem_bus_out,
  input wire logic       mem_bus_oe,
  input wire logic       mem_read_strobe_n,
  input wire logic       mem_write_strobe_n,
  input wire logic       mem_route_active,
  input wire logic [7:0] first_latch,
  input wire logic [7:0] first_pad_in,
  input wire logic [7:0] first_pad_out,
  input wire logic [7:0] first_pad_oe,
  input wire logic [7:0] first_pull_en,
  input wire logic [7:0] first_pin_level,
  input wire logic [7:0] second_latch,
  input wire logic [7:0] second_pad_out,
  input wire logic [7:0] second_pad_oe,
  input wire logic [7:0] second_pull_en
);
  logic mapped;
  assign mapped = (sfr_addr >= 8'hB1) && (sfr_addr <= 8'hB4);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_rd_hit_mapped: assert property (sfr_rd && mapped |=> sfr_rd_hit)
    else $error("read hit missing");
  a_unmapped_rd: assert property (!(sfr_rd && mapped) |=> !sfr_rd_hit && sfr_rdata == 8'h00)
    else $error("unmapped or idle read not zero");
  a_route_select: assert property (mem_route_active == (!external_access_pin_n || external_memory_select_bit))
    else $error("memory route select wrong");
  a_route_first: assert property (mem_route_active |=> first_pad_out == $past(mem_bus_out)
    && first_pad_oe == {8{$past(mem_bus_oe)}} && first_pull_en == 8'h00)
    else $error("first port not handed to memory");
  a_route_strobe: assert property (mem_route_active |=> second_pad_oe[7:6] == 2'h3
    && second_pad_out[7:6] == {$past(mem_read_strobe_n), $past(mem_write_strobe_n)}
    && second_pull_en[7:6] == 2'h0)
    else $error("strobe pins not driven");
  a_level_delay: assert property (1'b1 |=> first_pin_level == $past(first_pad_in))
    else $error("pin level not one cycle late");
  a_input_off: assert property (sfr_wr && sfr_addr == 8'hB3 && sfr_wdata[1:0] == 2'h3
    |=> ##1 !second_pad_oe[0] && !second_pull_en[0])
    else $error("input mode still drives");
  a_push_pull: assert property (sfr_wr && sfr_addr == 8'hB1 && sfr_wdata[1:0] == 2'h1
    ##1 !mem_route_active |=> first_pad_oe[0] && first_pad_out[0] == $past(first_latch[0]))
    else $error("push-pull pin wrong");
  a_open_drain: assert property (sfr_wr && sfr_addr == 8'hB4 && sfr_wdata[1:0] == 2'h2 ##1 1'b1
    |=> second_pad_oe[4] == !$past(second_latch[4]) && !second_pad_out[4]
    && !second_pull_en[4])
    else $error("open-drain pin wrong");
endmodule : pmc_port_mode_chk

bind pmc_port_mode pmc_port_mode_chk i_chk (.*);

// File: test/pmc_port_mode_test.sv
// self-checking bench for the pin mode block
`timescale 1ns/10ps

module pmc_port_mode_test;
  logic        clock, srst, sfr_wr, sfr_rd, sfr_rd_hit, mem_route_active;
  logic        external_access_pin_n, external_memory_select_bit, mem_bus_oe;
  logic        mem_read_strobe_n, mem_write_strobe_n;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, mem_bus_out, first_latch, second_latch;
  logic [7:0]  first_pad_in, first_pad_out, first_pad_oe, first_pull_en, first_pin_level;
  logic [7:0]  second_pad_in, second_pad_out, second_pad_oe, second_pull_en, second_pin_level;
  logic [23:0] e;
  logic [31:0] rows [6];
  logic [7:0]  lv [3];
  int          fails, check_count;

  pmc_port_mode i_dut (.*);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
    tick(1);
    sfr_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic h);
    sfr_rd = 1'b1; sfr_addr = a;
    tick(1);
    sfr_rd = 1'b0;
    chk({sfr_rdata, 7'h00, sfr_rd_hit}, {x, 7'h00, h});
    tick(1);
  endtask : rd

  function automatic logic [23:0] pins(input logic [15:0] m, input logic [7:0] l);
    logic [7:0] o, oe, p;
    o = 8'h00; oe = 8'h00; p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      case (m[2*i+:2])
        pmc_pkg::MODE_PULLUP: {oe[i], p[i]} = {~l[i], 1'b1};
        pmc_pkg::MODE_PUSH_PULL: {oe[i], o[i]} = {1'b1, l[i]};
        pmc_pkg::MODE_OPEN_DRAIN: oe[i] = ~l[i];
        default: oe[i] = 1'b0;
      endcase
    end
    return {o, oe, p};
  endfunction : pins

  task automatic close_out;
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (3000) @(posedge clock);
    fails++;
    close_out;
  end

  initial
  begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, mem_bus_out, mem_bus_oe} = '0;
    {external_access_pin_n, external_memory_select_bit} = 2'b10;
    {mem_read_strobe_n, mem_write_strobe_n} = 2'b01;
    {first_latch, second_latch, first_pad_in, second_pad_in} = {8'h3C, 8'hC3, 16'h0};
    rows = '{32'hB1555501, 32'hB2AAAA01, 32'hB3FFFF01, 32'hB41B1B01,
             32'hB5FF0000, 32'hB0120000};
    lv = '{8'h00, 8'hFF, 8'hA5};
    srst = 1'b1;
    tick(12);
    srst = 1'b0;
    tick(2);
    for (int i = 0; i < 4; i++) rd(8'hB1 + 8'(i), 8'h00, 1'b1);
    chk({first_pad_out, first_pad_oe, first_pull_en}, pins(16'h0, 8'h3C));
    foreach (rows[i]) wr(rows[i][31:24], rows[i][23:16]);
    foreach (rows[i]) rd(rows[i][31:24], rows[i][15:8], rows[i][0]);
    // pin mode table on both ports, all four codes in every mode register
    wr(8'hB1, 8'hE4);
    wr(8'hB2, 8'h1B);
    wr(8'hB3, 8'h39);
    wr(8'hB4, 8'hB1);
    foreach (lv[i])
    begin
      {first_latch, second_latch, first_pad_in, second_pad_in} = {lv[i], ~lv[i], lv[i] ^ 8'h0F, ~lv[i]};
      tick(2);
      chk({first_pad_out, first_pad_oe, first_pull_en}, pins(16'h1BE4, lv[i]));
      chk({second_pad_out, second_pad_oe, second_pull_en}, pins(16'hB139, ~lv[i]));
      chk({first_pin_level, second_pin_level, 8'h00}, {lv[i] ^ 8'h0F, ~lv[i], 8'h00});
    end
    // memory route, by the access pin and then by the select bit
    {mem_bus_out, mem_bus_oe} = {8'hC3, 1'b1};
    second_latch[7:6] = 2'b11;
    for (int k = 0; k < 2; k++)
    begin
      {external_access_pin_n, external_memory_select_bit} = k[0] ? 2'b11 : 2'b00;
      tick(2);
      chk({23'h0, mem_route_active}, 24'h1);
      chk({first_pad_out, first_pad_oe, first_pull_en}, {8'hC3, 8'hFF, 8'h00});
      e = pins(16'hB139, second_latch);
      e[23:22] = 2'b01;
      e[15:14] = 2'b11;
      e[7:6] = 2'b00;
      chk({second_pad_out, second_pad_oe, second_pull_en}, e);
    end
    {external_access_pin_n, external_memory_select_bit} = 2'b10;
    tick(1);
    chk({23'h0, mem_route_active}, 24'h0);
    // same-cycle read and write hands back the old value
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {2'b11, 8'hB1, 8'h00};
    tick(1);
    {sfr_wr, sfr_rd} = 2'b00;
    chk({16'h0, sfr_rdata}, {16'h0, 8'hE4});
    rd(8'hB1, 8'h00, 1'b1);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    rd(8'hB4, 8'h00, 1'b1);
    close_out;
  end
endmodule : pmc_port_mode_test
